// [rtl/serial_program_cmd_decoder.v]
// Serial programming instruction decoder, sampling the programmer's
// serial clock and data with the system clock. Assumes a memory
// controller behind the nvm_* port; read data is valid one cycle
// after a read request.
`timescale 1ns/10ps
`default_nettype none
`include "spi_prog_map.vh"

// Function
// [R1] Instructions are four bytes, fixed order
// [R2] Chip erase wipes flash and EEPROM
// [R3] Poll returns busy in bit zero
// [R4] Programmer waits for busy clear
// [R5] Opcode 4D stores extended address byte
// [R6] Opcode 48 loads page word high byte
// [R7] Opcode 40 loads page word low byte
// [R8] Programmer loads low byte before high
// [R9] Opcode 4C writes page buffer to flash
// [R10] Flash addresses are word addresses
// [R11] Opcodes 28/20 read high/low flash byte
// [R12] Opcode C1 loads EEPROM page buffer
// [R13] C2 writes EEPROM page, C0 byte
// [R14] Programmer commits EEPROM page afterwards
// [R15] Opcode 50 reads low/extended fuses
// [R16] AC A0/A8/A4 write fuses
// [R17] AC E0 writes lock bits
// [R18] Zero programmed, one unprogrammed
// [R19] Unused fuse bits left at one
// [R20] Sample on rise, shift out on fall
// [R21] Echo enable byte 53 during third
// [R22] Programmer sends enable after reset
// [R23] Ignore commands until enable accepted
module serial_program_cmd_decoder #(
  parameter [23:0] SIGNATURE = 24'h123456,
  parameter [7:0] CALIBRATION = 8'h80
) (
  input wire clk,
  input wire rst_n,
  input wire reset_pin,
  input wire sck,
  input wire mosi,
  output wire miso_o,
  output wire miso_oe,
  output reg [3:0] nvm_op_q,
  output reg [23:0] nvm_addr_q,
  output reg [7:0] nvm_wdata_q,
  output reg nvm_req_q,
  input wire nvm_busy,
  input wire [7:0] nvm_rdata,
  output reg [7:0] fuse_low_q,
  output reg [7:0] fuse_high_q,
  output reg [7:0] fuse_ext_q,
  output reg [7:0] lock_q,
  output reg prog_enabled_q
);

  // Bit 2 reset pin, bit 1 sck, bit 0 mosi
  reg [2:0] s1_q;
  reg [2:0] s2_q;
  reg [2:0] s3_q;
  reg [2:0] st_q;
  wire [2:0] agree;
  wire [2:0] st_d;
  wire prog_active;
  wire sck_rise;
  wire sck_fall;

  reg [31:0] sh_q;
  reg [4:0] cnt_q;
  reg byte_evt_q;
  reg [7:0] tx_q;
  reg miso_q;
  reg rd_pend_q;
  reg rd_take_q;
  reg [7:0] ext_addr_q;

  wire [7:0] b1;
  wire [7:0] b2;
  wire [7:0] b3;
  wire [7:0] w1;
  wire [7:0] w2;
  wire [7:0] w3;
  wire [7:0] w4;
  wire at_byte3;
  wire at_done;
  reg [7:0] resp;
  reg resp_rd;
  reg [3:0] rd_op;
  reg [23:0] rd_addr;
  reg wr_go;
  reg [3:0] wr_op;
  reg [23:0] wr_addr;

  // Three stages; a change is taken once stages two and three agree
  assign agree = ~(s2_q ^ s3_q);
  assign st_d = (agree & s3_q) | (~agree & st_q);
  assign prog_active = ~st_q[2];
  assign sck_rise = prog_active & agree[1] & s3_q[1] & ~st_q[1];
  assign sck_fall = prog_active & agree[1] & ~s3_q[1] & st_q[1];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= `SYNC_RST;
      s2_q <= `SYNC_RST;
      s3_q <= `SYNC_RST;
      st_q <= `SYNC_RST;
    end else begin
      s1_q <= {reset_pin, sck, mosi};
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= st_d;
    end
  end

  // Bytes as seen after three and after four received bytes
  assign b1 = sh_q[23:16];
  assign b2 = sh_q[15:8];
  assign b3 = sh_q[7:0];
  assign w1 = sh_q[31:24];
  assign w2 = sh_q[23:16];
  assign w3 = sh_q[15:8];
  assign w4 = sh_q[7:0];
  assign at_byte3 = byte_evt_q & (cnt_q == `CNT_BYTE3);
  assign at_done = byte_evt_q & (cnt_q == `CNT_DONE);

  assign miso_o = miso_q;
  assign miso_oe = prog_active;

  // Answer for the fourth byte slot
  always @* begin
    resp = 8'h00;
    resp_rd = 1'b0;
    rd_op = `NVM_RD_LO;
    rd_addr = {ext_addr_q, b2, b3}; // R10
    case (b1)
      `OPC_POLL: resp = {7'h00, nvm_busy}; // R3
      `OPC_READ_LOCK_FHI: begin
        if (b2 == `SUB_HIGH_EXT)
          resp = fuse_high_q;
        else
          resp = lock_q;
      end
      `OPC_READ_FUSE: begin
        if (b2 == `SUB_HIGH_EXT)
          resp = fuse_ext_q; // R15
        else
          resp = fuse_low_q; // R15
      end
      `OPC_READ_SIG: begin
        case (b3[1:0])
          2'h0: resp = SIGNATURE[23:16];
          2'h1: resp = SIGNATURE[15:8];
          default: resp = SIGNATURE[7:0];
        endcase
      end
      `OPC_READ_CAL: resp = CALIBRATION;
      `OPC_READ_HI: begin
        resp_rd = 1'b1;
        rd_op = `NVM_RD_HI; // R11
      end
      `OPC_READ_LO: begin
        resp_rd = 1'b1;
        rd_op = `NVM_RD_LO; // R11
      end
      `OPC_EE_READ: begin
        resp_rd = 1'b1;
        rd_op = `NVM_EE_RD;
        rd_addr = {14'h0000, b2[1:0], b3};
      end
      default: resp = 8'h00;
    endcase
  end

  // Memory operations started by a complete instruction
  always @* begin
    wr_go = 1'b0;
    wr_op = `NVM_CHIP_ERASE;
    wr_addr = 24'h000000;
    case (w1)
      `OPC_ENABLE_ERASE_FUSE: begin
        wr_go = (w2 == `SUB_ERASE); // R2
      end
      `OPC_LOAD_PAGE_HI: begin
        wr_go = 1'b1;
        wr_op = `NVM_PAGE_LD_HI; // R6
        wr_addr = {16'h0000, w3};
      end
      `OPC_LOAD_PAGE_LO: begin
        wr_go = 1'b1;
        wr_op = `NVM_PAGE_LD_LO; // R7
        wr_addr = {16'h0000, w3};
      end
      `OPC_WRITE_PAGE: begin
        wr_go = 1'b1;
        wr_op = `NVM_PAGE_WR; // R9
        wr_addr = {ext_addr_q, w2, w3}; // R10
      end
      `OPC_EE_LOAD: begin
        wr_go = 1'b1;
        wr_op = `NVM_EE_BUF_LD; // R12
        wr_addr = {16'h0000, w3};
      end
      `OPC_EE_PAGE_WRITE: begin
        wr_go = 1'b1;
        wr_op = `NVM_EE_PAGE_WR; // R13
        wr_addr = {14'h0000, w2[1:0], w3};
      end
      `OPC_EE_WRITE: begin
        wr_go = 1'b1;
        wr_op = `NVM_EE_WR; // R13
        wr_addr = {14'h0000, w2[1:0], w3};
      end
      default: wr_go = 1'b0;
    endcase
  end

  // Shift in on rise, count bits, flag each completed byte
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 32'h00000000;
      cnt_q <= 5'h00;
      byte_evt_q <= 1'b0;
    end else if (!prog_active) begin
      // Leaving programming drops any partial instruction
      cnt_q <= 5'h00;
      byte_evt_q <= 1'b0;
    end else begin
      byte_evt_q <= sck_rise & (cnt_q[2:0] == 3'h7);
      if (sck_rise) begin
        sh_q <= {sh_q[30:0], st_q[0]}; // R20
        cnt_q <= cnt_q + 5'h01; // R1
      end
    end
  end

  // Output byte; loaded at byte boundaries, shifted on fall
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= 8'h00;
      miso_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_take_q <= 1'b0;
    end else begin
      rd_pend_q <= 1'b0;
      // Read data is due the cycle after the request pulse
      rd_take_q <= rd_pend_q;
      if (!prog_active) begin
        tx_q <= 8'h00;
        miso_q <= 1'b0;
      end else if (sck_fall) begin
        miso_q <= tx_q[7]; // R20
        tx_q <= {tx_q[6:0], 1'b0};
      end else if (rd_take_q) begin
        tx_q <= nvm_rdata; // R11
      end else if (byte_evt_q) begin
        if (cnt_q == `CNT_BYTE3) begin
          tx_q <= prog_enabled_q ? resp : 8'h00; // R23
          rd_pend_q <= prog_enabled_q & resp_rd;
        end else if (cnt_q == `CNT_DONE) begin
          tx_q <= 8'h00;
        end else begin
          // Echo of the previous byte, 53 during the third
          tx_q <= sh_q[7:0]; // R21
        end
      end
    end
  end

  // Memory request port
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_op_q <= 4'h0;
      nvm_addr_q <= 24'h000000;
      nvm_wdata_q <= 8'h00;
      nvm_req_q <= 1'b0;
    end else begin
      nvm_req_q <= 1'b0;
      if (at_byte3 && prog_enabled_q && resp_rd) begin
        nvm_op_q <= rd_op;
        nvm_addr_q <= rd_addr;
        nvm_wdata_q <= 8'h00;
        nvm_req_q <= 1'b1;
      end else if (at_done && prog_enabled_q && wr_go) begin // R23
        nvm_op_q <= wr_op;
        nvm_addr_q <= wr_addr;
        nvm_wdata_q <= w4;
        nvm_req_q <= 1'b1;
      end
    end
  end

  // Enable flag, extended address, fuses and lock bits
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_enabled_q <= 1'b0;
      ext_addr_q <= 8'h00;
      fuse_low_q <= `FUSE_LOW_RST;
      fuse_high_q <= `FUSE_HIGH_RST;
      fuse_ext_q <= `FUSE_EXT_RST;
      lock_q <= `LOCK_RST;
    end else if (!prog_active) begin
      prog_enabled_q <= 1'b0; // R23
    end else if (at_done) begin
      if (w1 == `OPC_ENABLE_ERASE_FUSE && w2 == `SUB_ENABLE)
        prog_enabled_q <= 1'b1; // R23
      if (prog_enabled_q) begin
        if (w1 == `OPC_LOAD_EXT_ADDR)
          ext_addr_q <= w3; // R5
        if (w1 == `OPC_ENABLE_ERASE_FUSE) begin
          case (w2)
            `SUB_FUSE_LO_WR: fuse_low_q <= w4; // R16
            `SUB_FUSE_HI_WR: fuse_high_q <= w4; // R16
            `SUB_FUSE_EXT_WR: fuse_ext_q <= w4; // R16
            // Lock bits only move toward programmed (0)
            `SUB_LOCK_WR: lock_q <= lock_q & w4; // R17 R18
            // Erase returns lock bits to unprogrammed
            `SUB_ERASE: lock_q <= `LOCK_RST; // R2 R18
            default: lock_q <= lock_q;
          endcase
        end
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/spi_prog_map.vh]
// Constants for the serial programming command decoder.
// Assumes inclusion by the decoder only; holds definitions alone.
`ifndef SPI_PROG_MAP_VH
`define SPI_PROG_MAP_VH

// First instruction byte
`define OPC_ENABLE_ERASE_FUSE 8'hAC
`define OPC_POLL 8'hF0
`define OPC_LOAD_EXT_ADDR 8'h4D
`define OPC_LOAD_PAGE_HI 8'h48
`define OPC_LOAD_PAGE_LO 8'h40
`define OPC_WRITE_PAGE 8'h4C
`define OPC_READ_HI 8'h28
`define OPC_READ_LO 8'h20
`define OPC_EE_READ 8'hA0
`define OPC_EE_LOAD 8'hC1
`define OPC_EE_WRITE 8'hC0
`define OPC_EE_PAGE_WRITE 8'hC2
`define OPC_READ_LOCK_FHI 8'h58
`define OPC_READ_FUSE 8'h50
`define OPC_READ_SIG 8'h30
`define OPC_READ_CAL 8'h38

// Second instruction byte
`define SUB_ENABLE 8'h53
`define SUB_ERASE 8'h80
`define SUB_LOCK_WR 8'hE0
`define SUB_FUSE_LO_WR 8'hA0
`define SUB_FUSE_HI_WR 8'hA8
`define SUB_FUSE_EXT_WR 8'hA4
`define SUB_HIGH_EXT 8'h08

// Operations handed to the memory controller
`define NVM_CHIP_ERASE 4'h1
`define NVM_PAGE_LD_LO 4'h2
`define NVM_PAGE_LD_HI 4'h3
`define NVM_PAGE_WR 4'h4
`define NVM_RD_LO 4'h5
`define NVM_RD_HI 4'h6
`define NVM_EE_RD 4'h7
`define NVM_EE_BUF_LD 4'h8
`define NVM_EE_PAGE_WR 4'h9
`define NVM_EE_WR 4'hA

// Reset values
`define FUSE_LOW_RST 8'hFF
`define FUSE_HIGH_RST 8'hFF
`define FUSE_EXT_RST 8'hFF
`define LOCK_RST 8'hFF
`define SYNC_RST 3'h5

// Bit counts at byte boundaries
`define CNT_BYTE1 5'h08
`define CNT_BYTE2 5'h10
`define CNT_BYTE3 5'h18
`define CNT_DONE 5'h00

`endif

// [test/decoder_props_properties.sv]
// Checker: timing relations at the decoder's ports.
// Assumes a bind onto the decoder; only some of its ports are watched.
`timescale 1ns/10ps
`default_nettype none
module decoder_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reset_pin,
  input wire logic sck,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic [3:0] nvm_op_q,
  input wire logic nvm_req_q,
  input wire logic [7:0] fuse_low_q,
  input wire logic [7:0] lock_q,
  input wire logic prog_enabled_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Three sync stages plus the agree step: five high samples
  property p_oe_off; reset_pin [*5] |-> !miso_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("miso driven outside programming mode");
  property p_one_req; nvm_req_q |=> !nvm_req_q [*8]; endproperty
  a_one_req: assert property (p_one_req)
    else $error("memory request longer than one cycle");
  property p_req_en; nvm_req_q |-> prog_enabled_q; endproperty
  a_req_en: assert property (p_req_en)
    else $error("memory request while not enabled");
  property p_erase; nvm_req_q && nvm_op_q == 4'h1 |-> lock_q == 8'hFF;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase left lock bits programmed");
  property p_fuse; $changed(fuse_low_q) |-> $past(prog_enabled_q);
  endproperty
  a_fuse: assert property (p_fuse)
    else $error("fuse changed while not enabled");
  property p_lock;
    $changed(lock_q) |-> lock_q == 8'hFF || (lock_q & ~$past(lock_q)) == 8'h00;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock bit went back to unprogrammed");
  // Output moves only while the serial clock is low
  property p_miso; $changed(miso_o) && miso_oe |-> !$past(sck, 2); endproperty
  a_miso: assert property (p_miso)
    else $error("miso changed with serial clock high");
  property p_en_rise; $rose(prog_enabled_q) |-> miso_oe; endproperty
  a_en_rise: assert property (p_en_rise)
    else $error("enable accepted outside programming mode");
endmodule
bind serial_program_cmd_decoder decoder_props chk_u (
  .clk(clk),
  .rst_n(rst_n),
  .reset_pin(reset_pin),
  .sck(sck),
  .miso_o(miso_o),
  .miso_oe(miso_oe),
  .nvm_op_q(nvm_op_q),
  .nvm_req_q(nvm_req_q),
  .fuse_low_q(fuse_low_q),
  .lock_q(lock_q),
  .prog_enabled_q(prog_enabled_q)
);
`default_nettype wire

// [test/programmer_model.sv]
// Programmer model: clocks one four-byte instruction per call.
// Assumes the serial clock stands low between frames.
`timescale 1ns/10ps
`default_nettype none
module programmer_model (
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
  end
  task automatic xfer(input logic [31:0] cmd, output logic [31:0] ans);
    #13;
    for (int i = 31; i >= 0; i--) begin
      mosi = cmd[i];
      #160 sck = 1'b1;
      // Late in the high phase: the device output lags by sync stages
      #150 ans = {ans[30:0], miso};
      #10 sck = 1'b0;
    end
    mosi = ~mosi;
    #640;
  endtask
endmodule
`default_nettype wire

// [test/serial_program_cmd_decoder_test.sv]
// Testbench for the decoder, driving it through the programmer model.
// Assumes the checker binds itself; the memory model answers a read
// with a fixed byte only in the cycle after the request.
`timescale 1ns/10ps
`default_nettype none
module serial_program_cmd_decoder_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin = 1'b1;
  logic nvm_busy = 1'b0;
  logic [7:0] nvm_rdata = 8'h00;
  logic rd_due = 1'b0;
  wire sck, mosi, miso_o, miso_oe, nvm_req_q, prog_enabled_q;
  wire [3:0] nvm_op_q;
  wire [23:0] nvm_addr_q;
  wire [7:0] nvm_wdata_q, fuse_low_q, fuse_high_q, fuse_ext_q, lock_q;
  logic [3:0] op_seen;
  logic [23:0] addr_seen;
  logic [7:0] wd_seen;
  logic [31:0] ans;
  int errors = 0;
  int comparisons = 0;
  int reqs = 0;
  // Op, check flags, expected answer, instruction
  logic [47:0] rows [0:21] = '{48'h0000ACA000E5, 48'h01E550000000,
    48'h0000ACA800D9, 48'h01D958080000, 48'h0000ACA400FC,
    48'h01FC50080000, 48'h0000ACE000FC, 48'h0000ACE000FF,
    48'h01FC58000000, 48'h018038000000, 48'h00004D000200,
    48'h2000400011A5, 48'h30004800115A, 48'h42004C123400,
    48'h533C20123400, 48'h633C28123500, 48'h8000C1000277,
    48'h9000C201FC00, 48'hA000C0012399, 48'h713CA0012300,
    48'h011230000000, 48'h015630000200};
  serial_program_cmd_decoder #(
    .SIGNATURE(24'h123456),
    .CALIBRATION(8'h80)
  ) dut_u (
    .clk(clk),
    .rst_n(rst_n),
    .reset_pin(reset_pin),
    .sck(sck),
    .mosi(mosi),
    .miso_o(miso_o),
    .miso_oe(miso_oe),
    .nvm_op_q(nvm_op_q),
    .nvm_addr_q(nvm_addr_q),
    .nvm_wdata_q(nvm_wdata_q),
    .nvm_req_q(nvm_req_q),
    .nvm_busy(nvm_busy),
    .nvm_rdata(nvm_rdata),
    .fuse_low_q(fuse_low_q),
    .fuse_high_q(fuse_high_q),
    .fuse_ext_q(fuse_ext_q),
    .lock_q(lock_q),
    .prog_enabled_q(prog_enabled_q)
  );
  programmer_model prog_u (.sck(sck), .mosi(mosi), .miso(miso_o));
  always #20 clk = ~clk;
  // Data stands only in the cycle after a request, so early capture fails
  always @(negedge clk) nvm_rdata <= rd_due ? 8'h3C : 8'h00;
  always @(posedge clk) begin
    rd_due <= (nvm_req_q === 1'b1);
    if (nvm_req_q === 1'b1) begin
      op_seen <= nvm_op_q;
      addr_seen <= nvm_addr_q;
      wd_seen <= nvm_wdata_q;
      reqs <= reqs + 1;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic send(input logic [31:0] cmd);
    @(negedge clk);
    prog_u.xfer(cmd, ans);
    repeat (4) @(negedge clk);
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    check({fuse_low_q, fuse_high_q, fuse_ext_q, lock_q}, 32'hFFFFFFFF);
    reset_pin = 1'b0;
    repeat (8) @(negedge clk);
    send(32'hACA00000);
    check({prog_enabled_q, fuse_low_q, reqs[22:0]}, {1'b0, 8'hFF, 23'h0});
    send(32'hAC530000);
    check({ans[15:8], prog_enabled_q}, {8'h53, 1'b1});
    foreach (rows[i]) begin
      send(rows[i][31:0]);
      check(ans[23:16], rows[i][31:24]);
      if (rows[i][40])
        check(ans[7:0], rows[i][39:32]);
      if (rows[i][41])
        check(addr_seen, {8'h02, rows[i][23:8]});
      if (rows[i][47:44] != 4'h0)
        check({op_seen, wd_seen}, {rows[i][47:44], rows[i][7:0]});
    end
    nvm_busy = 1'b1;
    send(32'hF0000000);
    check(ans[0], 1'b1);
    nvm_busy = 1'b0;
    send(32'hF0000000);
    check(ans[0], 1'b0);
    send(32'hAC800000);
    check({op_seen, lock_q}, {4'h1, 8'hFF});
    reset_pin = 1'b1;
    repeat (6) @(negedge clk);
    check({prog_enabled_q, miso_oe}, 2'b00);
    // Mid-run reset returns the programmed fuses to unprogrammed
    rst_n = 1'b0;
    @(negedge clk);
    check({fuse_low_q, fuse_high_q, fuse_ext_q, lock_q}, 32'hFFFFFFFF);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    end_of_test;
  end
  // Roughly four times the expected run
  initial begin
    #1_200_000;
    errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
